/* epw_ee_model.sv */
// Behavioural model of the byte-wide page-mode memory on the far side
`timescale 1ns/1ps
`default_nettype none

module epw_ee_model #(
  parameter int WIN_NS = 400,
  parameter int WC_NS  = 2000,
  parameter int ACC_NS = 200
) (
  // Control pins
  input  wire logic        ceN,
  input  wire logic        oeN,
  input  wire logic        weN,
  input  wire logic [12:0] addr,
  // Data lines
  input  wire logic [7:0]  hostData,
  input  wire logic        hostOe,
  output logic [7:0]       lineLevel,
  // Fault injection
  input  wire logic        stuck
);
  logic [7:0]  mem [0:8191];
  logic [7:0]  page [0:63];
  logic [63:0] used;
  logic [6:0]  row;
  logic [5:0]  col;
  logic        armed;
  logic        loading;
  logic        busy;
  logic [7:0]  lastByte;
  logic [7:0]  floatVal;
  time         riseT;
  wire         rdDrive = !ceN && !oeN && weN;
  wire [7:0]   rdVal   = (busy || loading) ? ~lastByte : mem[addr];
  wire         rdDriveD;
  wire [7:0]   rdValD;

  assign #(ACC_NS) rdDriveD = rdDrive;
  assign #(ACC_NS) rdValD = rdVal;

  initial begin
    for (int i = 0; i < 8192; i++) mem[i] = 8'(i) ^ 8'hA5;
    used = 64'h0;
    armed = 1'b0;
    loading = 1'b0;
    busy = 1'b0;
    lastByte = 8'h00;
    floatVal = 8'h5A;
    riseT = 0;
  end

  // ==========================================================
  // Data line level
  always_comb begin
    if (hostOe && rdDrive) lineLevel = 8'hXX;
    else if (hostOe) lineLevel = hostData;
    else if (rdDrive && rdDriveD) lineLevel = rdValD;
    else lineLevel = floatVal;
  end

  // Released lines show the inverse of what they last carried
  always @(negedge hostOe) floatVal = ~hostData;
  always @(negedge rdDrive) floatVal = ~rdValD;

  // ==========================================================
  // Byte loading
  always @(negedge weN or negedge ceN) begin
    if (!weN && !ceN && oeN && !busy) begin
      if (!loading) row = addr[12:6];
      col = addr[5:0];
      loading = 1'b1;
      armed = 1'b1;
    end
  end

  always @(posedge weN or posedge ceN) begin
    if (armed) begin
      page[col] = lineLevel;
      used[col] = 1'b1;
      lastByte = lineLevel;
      riseT = $time;
      armed = 1'b0;
    end
  end

  // ==========================================================
  // Page-load timer and internal write
  always #10 begin
    if (loading && !armed && ($time - riseT >= WIN_NS)) begin
      busy = 1'b1;
      loading = 1'b0;
      #(WC_NS);
      wait (!stuck);
      for (int i = 0; i < 64; i++) if (used[i]) mem[{row, 6'(i)}] = 8'hFF;
      for (int i = 0; i < 64; i++) if (used[i]) mem[{row, 6'(i)}] = page[i];
      used = 64'h0;
      busy = 1'b0;
    end
  end
endmodule // epw_ee_model

`default_nettype wire

/* epw_mem_if.sv */
// Port bundle between the controller and its page buffer
`timescale 1ns/1ps
`default_nettype none

interface epw_mem_if #(
  parameter int DEPTH = 64
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic          wrEn;
  logic [AW-1:0] wrAddr;
  logic [7:0]    wrData;
  logic [AW-1:0] rdAddr;
  logic [7:0]    rdData;

  modport writer (output wrEn, output wrAddr, output wrData, output rdAddr, input rdData);
  modport store  (input wrEn, input wrAddr, input wrData, input rdAddr, output rdData);
endinterface

`default_nettype wire

/* epw_page_mem.sv */
// Page buffer: one write port, registered read port
`timescale 1ns/1ps
`default_nettype none

module epw_page_mem #(
  parameter int DEPTH = 64
) (
  // Clock and reset
  input  wire logic  ref_clk,
  input  wire logic  rst_b,
  // Buffer ports
  epw_mem_if.store   mem
);
  logic [7:0] store [DEPTH];

  always_ff @(posedge ref_clk) begin
    if (mem.wrEn) begin
      store[mem.wrAddr] <= mem.wrData;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mem.rdData <= 8'h00;
    end else begin
      mem.rdData <= store[mem.rdAddr];
    end
  end
endmodule // epw_page_mem

`default_nettype wire

/* epw_page_writer.sv */
// Host-side controller driving a byte-wide page-mode EEPROM
// Notes on behaviour
// - Reads hold address steady, chip select low, write strobe high throughout.
// - Write starts on strobe fall with chip selected, output drive high, address valid.
// - A page load carries one to 64 bytes, in consecutive columns from the start column, wrapping within the row.
// - Host holds the write strobe low at least the minimum pulse width.
`timescale 1ns/1ps
`default_nettype none
`include "epw_regs.svh"

module epw_page_writer #(
  parameter int PAGE_BYTES = `EPW_PAGE_MAX,
  parameter int POLL_LIMIT = `EPW_WC_NS / `EPW_CLK_NS,
  parameter int WINDOW_NS  = `EPW_PAGE_WINDOW_NS
) (
  // Clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     rst_b,
  // Command
  input  wire logic                     cmdValid,
  output logic                          cmdReady,
  input  wire epw_pkg::epw_op_type      cmdOp,
  input  wire logic [`EPW_ADDR_W-1:0]   cmdAddr,
  input  wire logic [6:0]               cmdCount,
  // Page buffer load
  input  wire logic                     loadValid,
  input  wire logic [`EPW_COL_MSB:0]    loadIndex,
  input  wire logic [`EPW_DATA_W-1:0]   loadData,
  // Completion
  output logic                          doneValid,
  output logic [`EPW_DATA_W-1:0]        doneData,
  output logic                          doneTimeout,
  // Memory pins
  output logic [`EPW_ADDR_W-1:0]        eeAddr,
  output logic                          eeCeN,
  output logic                          eeOeN,
  output logic                          eeWeN,
  output logic [`EPW_DATA_W-1:0]        eeDataOut,
  output logic                          eeDataOe,
  input  wire logic [`EPW_DATA_W-1:0]   eeDataIn
);
  import epw_pkg::*;

  // ==========================================================
  // Cycle counts
  localparam int AsCyc    = (`EPW_AS_NS + `EPW_CLK_NS - 1) / `EPW_CLK_NS;
  localparam int WpCyc    = (`EPW_WP_NS + `EPW_CLK_NS - 1) / `EPW_CLK_NS;
  localparam int DhCyc    = (`EPW_DH_NS + `EPW_CLK_NS - 1) / `EPW_CLK_NS;
  localparam int AccCyc   = (`EPW_ACC_NS + `EPW_CLK_NS - 1) / `EPW_CLK_NS;
  localparam int DfCyc    = (`EPW_DF_NS + `EPW_CLK_NS - 1) / `EPW_CLK_NS;
  localparam int SetupCyc = (AsCyc > 3) ? AsCyc : 3;
  localparam int GapMax   = DhCyc + SetupCyc + 1;
  localparam int ColMask  = PAGE_BYTES - 1;

  if (PAGE_BYTES < 1 || PAGE_BYTES > `EPW_PAGE_MAX || (PAGE_BYTES & ColMask) != 0) begin : gBadPage
    $error("PAGE_BYTES must be a power of two up to 64");
  end
  if (POLL_LIMIT < 1) begin : gBadPoll
    $error("POLL_LIMIT must be positive");
  end
  if ((GapMax + WpCyc) * `EPW_CLK_NS >= WINDOW_NS) begin : gBadWindow
    $error("Byte cadence does not fit the page-load window");
  end

  function automatic logic [5:0] colOf(input logic [5:0] start, input logic [6:0] idx);
    colOf = (start + idx[5:0]) & 6'(ColMask);
  endfunction

  // ==========================================================
  // Page buffer
  epw_mem_if #(.DEPTH(`EPW_PAGE_MAX)) mem ();

  epw_page_mem #(.DEPTH(`EPW_PAGE_MAX)) uMem (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .mem     (mem.store)
  );

  // ==========================================================
  // Read data synchroniser
  logic [7:0] dataMeta;
  logic [7:0] dataSync;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dataMeta <= `EPW_DATA_RST;
      dataSync <= `EPW_DATA_RST;
    end else begin
      dataMeta <= eeDataIn;
      dataSync <= dataMeta;
    end
  end

  // ==========================================================
  // Sequencer
  epw_state_type state, next_state;
  logic [31:0]   cnt, next_cnt;
  logic [31:0]   pollCnt, next_pollCnt;
  logic [6:0]    byteIdx, next_byteIdx;
  logic [6:0]    byteTotal, next_byteTotal;
  logic [5:0]    startCol, next_startCol;
  logic [5:0]    curCol, next_curCol;
  logic [6:0]    pageRow, next_pageRow;
  logic [7:0]    lastData, next_lastData;
  logic [12:0]   next_eeAddr;
  logic          next_eeCeN, next_eeOeN, next_eeWeN, next_eeDataOe;
  logic [7:0]    next_eeDataOut;
  logic          next_doneValid, next_doneTimeout;
  logic [7:0]    next_doneData;
  logic          moreBytes;

  assign cmdReady   = (state == ST_IDLE);
  assign moreBytes  = (byteIdx + 7'h01) < byteTotal;
  assign mem.wrEn   = loadValid;
  assign mem.wrAddr = loadIndex;
  assign mem.wrData = loadData;
  assign mem.rdAddr = curCol;

  always_comb begin
    next_state       = state;
    next_cnt         = cnt + 32'h1;
    next_pollCnt     = pollCnt;
    next_byteIdx     = byteIdx;
    next_byteTotal   = byteTotal;
    next_startCol    = startCol;
    next_curCol      = curCol;
    next_pageRow     = pageRow;
    next_lastData    = lastData;
    next_eeAddr      = eeAddr;
    next_eeCeN       = eeCeN;
    next_eeOeN       = eeOeN;
    next_eeWeN       = eeWeN;
    next_eeDataOut   = eeDataOut;
    next_eeDataOe    = eeDataOe;
    next_doneValid   = 1'b0;
    next_doneData    = doneData;
    next_doneTimeout = doneTimeout;
    case (state)
      ST_IDLE: begin
        next_cnt = 32'h0;
        if (cmdValid) begin
          next_eeAddr   = cmdAddr;
          next_pageRow  = cmdAddr[`EPW_ROW_MSB:`EPW_ROW_LSB];
          next_startCol = cmdAddr[`EPW_COL_MSB:0];
          next_curCol   = cmdAddr[`EPW_COL_MSB:0];
          next_byteIdx  = 7'h00;
          if (cmdCount == 7'h00) begin
            next_byteTotal = 7'h01;
          end else if (cmdCount > 7'(PAGE_BYTES)) begin
            next_byteTotal = 7'(PAGE_BYTES);
          end else begin
            next_byteTotal = cmdCount;
          end
          next_eeCeN = 1'b0;
          if (cmdOp == OP_READ) begin
            next_eeOeN = 1'b0;
            next_state = ST_RD_ACC;
          end else begin
            next_eeOeN    = 1'b1;
            next_eeDataOe = 1'b1;
            next_state    = ST_WR_SETUP;
          end
        end
      end
      ST_RD_ACC: begin
        if (cnt == 32'(AccCyc + 2)) begin
          next_doneValid   = 1'b1;
          next_doneData    = dataSync;
          next_doneTimeout = 1'b0;
          next_eeCeN       = 1'b1;
          next_eeOeN       = 1'b1;
          next_state       = ST_IDLE;
        end
      end
      ST_WR_SETUP: begin
        next_eeAddr    = {pageRow, curCol};
        next_eeDataOut = mem.rdData;
        if (cnt == 32'(SetupCyc - 1)) begin
          next_eeWeN    = 1'b0;
          next_lastData = mem.rdData;
          next_cnt      = 32'h0;
          next_state    = ST_WR_PULSE;
        end
      end
      ST_WR_PULSE: begin
        if (cnt == 32'(WpCyc - 1)) begin
          next_eeWeN = 1'b1;
          next_cnt   = 32'h0;
          next_state = ST_WR_HOLD;
        end
      end
      ST_WR_HOLD: begin
        if (cnt == 32'(DhCyc - 1)) begin
          next_cnt = 32'h0;
          if (moreBytes) begin
            // Address moves a full setup span ahead of the next strobe fall
            next_eeAddr  = {pageRow, colOf(startCol, byteIdx + 7'h01)};
            next_byteIdx = byteIdx + 7'h01;
            next_curCol  = colOf(startCol, byteIdx + 7'h01);
            next_state   = ST_WR_SETUP;
          end else begin
            next_eeDataOe = 1'b0;
            next_pollCnt  = 32'h0;
            next_state    = ST_POLL_GAP;
          end
        end
      end
      ST_POLL_GAP: begin
        next_pollCnt = pollCnt + 32'h1;
        if (cnt == 32'(DfCyc - 1)) begin
          next_eeOeN = 1'b0;
          next_cnt   = 32'h0;
          next_state = ST_POLL_ACC;
        end
      end
      ST_POLL_ACC: begin
        next_pollCnt = pollCnt + 32'h1;
        if (cnt == 32'(AccCyc + 2)) begin
          next_cnt   = 32'h0;
          next_eeOeN = 1'b1;
          if (dataSync == lastData || pollCnt >= 32'(POLL_LIMIT)) begin
            next_doneValid   = 1'b1;
            next_doneData    = dataSync;
            next_doneTimeout = (dataSync != lastData);
            next_eeCeN       = 1'b1;
            next_state       = ST_IDLE;
          end else begin
            next_state = ST_POLL_GAP;
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state       <= ST_IDLE;
      cnt         <= 32'h0;
      pollCnt     <= 32'h0;
      byteIdx     <= 7'h00;
      byteTotal   <= 7'h01;
      startCol    <= 6'h00;
      curCol      <= 6'h00;
      pageRow     <= 7'h00;
      lastData    <= `EPW_DATA_RST;
      eeAddr      <= `EPW_ADDR_RST;
      eeCeN       <= `EPW_STROBE_RST;
      eeOeN       <= `EPW_STROBE_RST;
      eeWeN       <= `EPW_STROBE_RST;
      eeDataOut   <= `EPW_DATA_RST;
      eeDataOe    <= 1'b0;
      doneValid   <= 1'b0;
      doneData    <= `EPW_DATA_RST;
      doneTimeout <= 1'b0;
    end else begin
      state       <= next_state;
      cnt         <= next_cnt;
      pollCnt     <= next_pollCnt;
      byteIdx     <= next_byteIdx;
      byteTotal   <= next_byteTotal;
      startCol    <= next_startCol;
      curCol      <= next_curCol;
      pageRow     <= next_pageRow;
      lastData    <= next_lastData;
      eeAddr      <= next_eeAddr;
      eeCeN       <= next_eeCeN;
      eeOeN       <= next_eeOeN;
      eeWeN       <= next_eeWeN;
      eeDataOut   <= next_eeDataOut;
      eeDataOe    <= next_eeDataOe;
      doneValid   <= next_doneValid;
      doneData    <= next_doneData;
      doneTimeout <= next_doneTimeout;
    end
  end

  // ==========================================================
  // Checks
  logic [31:0] weLowCnt;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      weLowCnt <= 32'h0;
    end else begin
      weLowCnt <= eeWeN ? 32'h0 : weLowCnt + 32'h1;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence byteEndSeq;
    $rose(eeWeN) && moreBytes;
  endsequence

  sequence nextByteSeq;
    ##[1:GapMax] $fell(eeWeN);
  endsequence

  read_we_high_a: assert property ((!eeOeN && !eeCeN) |-> eeWeN)
    else $error("Write strobe low during a read");
  read_addr_steady_a: assert property ((!eeOeN && $past(!eeOeN)) |-> $stable(eeAddr))
    else $error("Address moved during a read");
  write_start_a: assert property ($fell(eeWeN) |-> (!eeCeN && eeOeN && eeDataOe))
    else $error("Write strobe fell outside the write combination");
  no_contention_a: assert property (eeDataOe |-> eeOeN)
    else $error("Data driven while output drive asserted");
  pulse_width_a: assert property ($rose(eeWeN) |-> weLowCnt == 32'(WpCyc))
    else $error("Write pulse width wrong");
  row_locked_a: assert property ($fell(eeWeN) |-> eeAddr[12:6] == pageRow)
    else $error("Row address changed within a page load");
  byte_count_a: assert property ($fell(eeWeN) |-> byteIdx < byteTotal && byteTotal <= 7'(PAGE_BYTES))
    else $error("Too many bytes in one page load");
  byte_cadence_a: assert property (byteEndSeq |-> nextByteSeq)
    else $error("Next byte missed the page-load window");
  poll_quiet_a: assert property ((state == ST_POLL_ACC || state == ST_POLL_GAP) |-> eeWeN)
    else $error("Write strobe moved while polling");
  poll_match_a: assert property ((doneValid && !doneTimeout && $past(state) == ST_POLL_ACC) |-> doneData == lastData)
    else $error("Page write finished without a true poll read");

endmodule // epw_page_writer

`default_nettype wire

/* epw_page_writer_tb.sv */
// Self-checking bench for the page-write controller against a memory model
`timescale 1ns/1ps
`default_nettype none

module epw_page_writer_tb;
  import epw_pkg::*;

  logic        ref_clk     = 1'b0;
  logic        rst_b       = 1'b0;
  logic        cmdValid    = 1'b0;
  epw_op_type  cmdOp       = OP_READ;
  logic [12:0] cmdAddr     = 13'h0000;
  logic [6:0]  cmdCount    = 7'h00;
  logic        loadValid   = 1'b0;
  logic [5:0]  loadIndex   = 6'h00;
  logic [7:0]  loadData    = 8'h00;
  logic        stuck       = 1'b0;
  logic        weLast      = 1'b1;
  logic [12:0] addrLast    = 13'h0000;
  logic        cmdReady, doneValid, doneTimeout, eeCeN, eeOeN, eeWeN, eeDataOe;
  logic [7:0]  doneData, eeDataOut, eeDataIn;
  logic [12:0] eeAddr;
  int          weLow       = 0;
  int          failures    = 0;
  int          comparisons = 0;

  always #2 ref_clk = ~ref_clk;

  epw_page_writer #(.POLL_LIMIT(4000), .WINDOW_NS(400)) dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .cmdValid(cmdValid), .cmdReady(cmdReady),
    .cmdOp(cmdOp), .cmdAddr(cmdAddr), .cmdCount(cmdCount), .loadValid(loadValid),
    .loadIndex(loadIndex), .loadData(loadData), .doneValid(doneValid),
    .doneData(doneData), .doneTimeout(doneTimeout), .eeAddr(eeAddr), .eeCeN(eeCeN),
    .eeOeN(eeOeN), .eeWeN(eeWeN), .eeDataOut(eeDataOut), .eeDataOe(eeDataOe),
    .eeDataIn(eeDataIn));

  epw_ee_model #(.WIN_NS(400), .WC_NS(2000), .ACC_NS(200)) memModel (
    .ceN(eeCeN), .oeN(eeOeN), .weN(eeWeN), .addr(eeAddr), .hostData(eeDataOut),
    .hostOe(eeDataOe), .lineLevel(eeDataIn), .stuck(stuck));

  // ==========================================================
  // Shared tasks
  task automatic check(input logic [12:0] got, input logic [12:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic give_verdict;
    $display("Comparisons %0d, failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic run_cmd(input epw_op_type op, input logic [12:0] addr,
                         input logic [6:0] cnt, output int cyc);
    cmdOp = op;
    cmdAddr = addr;
    cmdCount = cnt;
    cmdValid = 1'b1;
    // Ready is judged between edges, then the next edge takes the command
    while (cmdReady !== 1'b1) begin
      @(posedge ref_clk);
      #1;
    end
    @(posedge ref_clk);
    #1;
    cmdValid = 1'b0;
    cyc = 0;
    do begin
      @(posedge ref_clk);
      #1;
      cyc++;
    end while (doneValid !== 1'b1 && cyc < 30000);
    check(cyc < 30000, 1'b1);
  endtask

  task automatic do_read(input logic [12:0] addr, input logic [7:0] exp);
    int cyc;
    run_cmd(OP_READ, addr, 7'h00, cyc);
    check(doneData, exp);
    check(cyc, 66);
  endtask

  task automatic do_write(input logic [12:0] addr, input logic [6:0] cnt, input int n,
                          input logic [7:0] base, input logic expTo);
    int cyc;
    logic [7:0] last;
    last = base + 8'(n - 1);
    for (int k = 0; k < n; k++) begin
      @(posedge ref_clk);
      #1;
      loadValid = 1'b1;
      loadIndex = addr[5:0] + 6'(k);
      loadData = base + 8'(k);
    end
    @(posedge ref_clk);
    #1;
    loadValid = 1'b0;
    run_cmd(OP_WRITE, addr, cnt, cyc);
    check(doneTimeout, expTo);
    check(doneData, expTo ? 8'(~last) : last);
    if (!expTo) check({memModel.busy, memModel.loading}, 2'b00);
  endtask

  // ==========================================================
  // Pin protocol monitor
  always @(posedge ref_clk) begin
    if (rst_b) begin
      if (!eeCeN && !eeOeN) check(eeWeN, 1'b1);
      if (!eeWeN) check({eeCeN, eeOeN}, 2'b01);
      if (!eeWeN && !weLast) check(eeAddr, addrLast);
      if (eeWeN && !weLast) check(weLow >= 38, 1'b1);
      weLow <= eeWeN ? 0 : weLow + 1;
    end
    weLast <= eeWeN;
    addrLast <= eeAddr;
  end

  // ==========================================================
  // Scenarios
  task automatic s_reset;
    check({eeCeN, eeOeN, eeWeN, eeDataOe, doneValid, doneTimeout}, 6'b111000);
    check(eeAddr, 13'h0000);
    check(doneData, 8'h00);
    check(cmdReady, 1'b1);
  endtask

  task automatic s_read;
    do_read(13'h1ABC, 8'hBC ^ 8'hA5);
    do_read(13'h0041, 8'h41 ^ 8'hA5);
  endtask

  task automatic s_wrap;
    do_write(13'h017E, 7'h03, 3, 8'h10, 1'b0);
    do_read(13'h017E, 8'h10);
    do_read(13'h017F, 8'h11);
    do_read(13'h0140, 8'h12);
    do_read(13'h0141, 8'hE4);
    do_read(13'h0180, 8'h25);
  endtask

  task automatic s_counts;
    do_write(13'h0087, 7'h00, 1, 8'h77, 1'b0);
    do_read(13'h0087, 8'h77);
    do_read(13'h0088, 8'h2D);
    do_write(13'h00C0, 7'h64, 64, 8'h40, 1'b0);
    for (int k = 0; k < 64; k++) do_read(13'h00C0 + 13'(k), 8'h40 + 8'(k));
  endtask

  task automatic s_timeout;
    int n;
    n = 0;
    stuck = 1'b1;
    do_write(13'h0244, 7'h01, 1, 8'h9C, 1'b1);
    stuck = 1'b0;
    while (memModel.busy === 1'b1 && n < 1000) begin
      @(posedge ref_clk);
      n++;
    end
    @(posedge ref_clk);
    #1;
    check(memModel.busy, 1'b0);
    do_read(13'h0244, 8'h9C);
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (16) @(posedge ref_clk);
    #1;
    s_reset();
    rst_b = 1'b1;
    s_read();
    s_wrap();
    s_counts();
    s_timeout();
    give_verdict();
  end

  initial begin
    #200000;
    failures++;
    give_verdict();
  end
endmodule // epw_page_writer_tb

`default_nettype wire

/* epw_pkg.sv */
// Types shared by the page-write controller
package epw_pkg;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_RD_ACC   = 3'b001,
    ST_WR_SETUP = 3'b010,
    ST_WR_PULSE = 3'b011,
    ST_WR_HOLD  = 3'b100,
    ST_POLL_GAP = 3'b101,
    ST_POLL_ACC = 3'b110
  } epw_state_type;

  typedef enum logic {
    OP_READ  = 1'b0,
    OP_WRITE = 1'b1
  } epw_op_type;

endpackage

/* epw_regs.svh */
// Timing, field and reset constants of the page-write controller
`ifndef EPW_REGS_SVH
`define EPW_REGS_SVH

// ==========================================================
// Clock
`define EPW_CLK_NS          4
// ==========================================================
// Pin timing in nanoseconds
`define EPW_AS_NS           10
`define EPW_WP_NS           150
`define EPW_DH_NS           20
`define EPW_ACC_NS          250
`define EPW_DF_NS           60
`define EPW_PAGE_WINDOW_NS  100000
// ==========================================================
// Internal write time in nanoseconds (10 ms)
`define EPW_WC_NS           10000000
// ==========================================================
// Address fields
`define EPW_ROW_MSB         12
`define EPW_ROW_LSB         6
`define EPW_COL_MSB         5
`define EPW_ADDR_W          13
`define EPW_DATA_W          8
`define EPW_PAGE_MAX        64
// ==========================================================
// Reset values
`define EPW_STROBE_RST      1'b1
`define EPW_ADDR_RST        13'h0000
`define EPW_DATA_RST        8'h00

`endif
